// ==== design/fpec_defs.vh ====
// constants and register map of the flash program/erase controller
// How it works
// - page select bit 7 enables info area overlaying FE00h..FFFFh
// - data reads see info area when enabled; fetches always see main array
// - info area is read-only; writes into it never change it
// - info bytes FE40h..FE53h hold 20-char part id, zero padded
// - reset leaves the controller locked
// - out-of-sequence command or page select write locks the controller
// - unlock order: 00h, page, 73h, 8Ch, same page again
// - command 5Eh maps sector protect at page select address; others unmap
// - sector protect clears on reset; user writes can only set bits
// - unlocked user write programs only inside the unlocked page
// - programming only clears bits; erase returns bytes to FFh
// - user program or page erase refused in protected sectors
// - processor stalled during program or erase; clock keeps running
// - command 00h leaves programming mode and locks
// - command 95h after unlock erases selected page, then locks
// - whole-array erase refused from user code
// - write-protect option bit blocks all user program and erase
// - read-protect option bit blocks debugger reads of flash
// - debugger ignores write-protect and sector protect, skips second page write, may mass erase
// - user code: one page open per unlock, another needs a new unlock; debugger page writes reselect it while open
// - command 63h is whole-array erase, debugger only
// - status field encodes locked, unlock steps, unlocked, busy kinds
// - page select bits 6:0 give flash address bits 15:9
`ifndef FPEC_DEFS_VH
`define FPEC_DEFS_VH
`define FPEC_ADDR_CTRL 12'hFF8
`define FPEC_ADDR_PAGE 12'hFF9
`define FPEC_ADDR_FRQH 12'hFFA
`define FPEC_ADDR_FRQL 12'hFFB
`define FPEC_CMD_RESET 8'h00
`define FPEC_CMD_UNLK1 8'h73
`define FPEC_CMD_UNLK2 8'h8C
`define FPEC_CMD_PERASE 8'h95
`define FPEC_CMD_MERASE 8'h63
`define FPEC_CMD_PROT 8'h5E
`define FPEC_INFO_AREA_ENABLE_BIT 7
`define FPEC_INFO_BASE 7'h7F
`define FPEC_ID_LO 9'h040
`define FPEC_ID_HI 9'h053
`define FPEC_ERASED 8'hFF
`define FPEC_ST_LOCK 6'h00
`define FPEC_ST_U1 6'h01
`define FPEC_ST_U2 6'h02
`define FPEC_ST_OPEN 6'h03
`define FPEC_ST_PROT 6'h04
`define FPEC_ST_PROG 6'h08
`define FPEC_ST_PERASE 6'h10
`define FPEC_ST_MERASE 6'h20
// program time per byte in us, erase time per page in ms (nominal)
`define FPEC_T_PROG_US 16'd40
`define FPEC_T_ERASE_MS 16'd10
`endif

// ==== design/fpec_timer.v ====
// operation timer counting 1 us ticks derived from the khz setting
`timescale 1ns/10ps
module fpec_timer (
	// clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// control
	input wire start_i,
	input wire [15:0] khz_i,
	input wire [15:0] us_i,
	// status
	output reg done_o
);
	reg [15:0] cyc_reg;
	reg [15:0] us_reg;
	reg run_reg;
	// khz/1000 cycles per us; clamp to one so slow clocks still finish
	wire [15:0] per_us = (khz_i < 16'd1000) ? 16'd1 : khz_i / 16'd1000;
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cyc_reg <= 16'h0000;
			us_reg <= 16'h0000;
			run_reg <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				run_reg <= 1'b1;
				cyc_reg <= 16'h0000;
				us_reg <= 16'h0000;
			end else if (run_reg) begin
				if (cyc_reg + 16'd1 >= per_us) begin
					cyc_reg <= 16'h0000;
					if (us_reg + 16'd1 >= us_i) begin
						run_reg <= 1'b0;
						done_o <= 1'b1;
					end else begin
						us_reg <= us_reg + 16'd1;
					end
				end else begin
					cyc_reg <= cyc_reg + 16'd1;
				end
			end
		end
	end
endmodule

// ==== design/fpec_ctrl.v ====
// flash program/erase controller: unlock, protection, overlay, sequencing
`timescale 1ns/10ps
`include "fpec_defs.vh"
module fpec_ctrl #(
	parameter MEM_AW = 16,
	parameter ERASE_US = 10000
) (
	// clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// register file port
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [11:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	// program memory port
	input wire mem_wr_i,
	input wire mem_rd_i,
	input wire mem_fetch_i,
	input wire [15:0] mem_addr_i,
	input wire [7:0] mem_wdata_i,
	output reg [7:0] mem_rdata_o,
	output reg mem_rvalid_o,
	// access source and option bits (from other logic, same clock)
	input wire dbg_mode_i,
	input wire opt_wr_protect_i,
	input wire opt_rd_protect_i,
	// processor stall
	output reg cpu_stall_o,
	// state
	output reg [5:0] flash_state_field_o
);
	localparam S_LOCK = 3'd0;
	localparam S_U1 = 3'd1;
	localparam S_U2 = 3'd2;
	localparam S_OPEN = 3'd3;
	localparam S_PROT = 3'd4;
	localparam S_PROG = 3'd5;
	localparam S_PER = 3'd6;
	localparam S_MER = 3'd7;
	localparam [6:0] PAGES = 7'h7F;

	reg [7:0] flash_mem [0:(1<<MEM_AW)-1];
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [7:0] flash_page_select_reg;
	reg [7:0] sector_protect_mask_reg;
	reg [15:0] clock_khz_setting_reg;
	reg [6:0] open_page_reg;
	reg [15:0] pg_addr_reg;
	reg [7:0] pg_data_reg;
	reg [8:0] er_idx_reg;
	reg [6:0] er_page_reg;
	reg tmr_start_reg;
	reg work_done_reg;
	wire tmr_done;

	// sector of a page: top three page bits
	function prot_hit;
		input [6:0] pg;
		input [7:0] mask;
		begin
			prot_hit = mask[pg[6:4]];
		end
	endfunction

	// part id string, arbitrary content, zero padded
	function [7:0] info_byte;
		input [8:0] off;
		begin
			info_byte = 8'h00;
			if (off >= `FPEC_ID_LO && off <= `FPEC_ID_HI) begin
				case (off - `FPEC_ID_LO)
				9'd0: info_byte = 8'h46;
				9'd1: info_byte = 8'h50;
				9'd2: info_byte = 8'h45;
				9'd3: info_byte = 8'h43;
				9'd4: info_byte = 8'h30;
				9'd5: info_byte = 8'h31;
				default: info_byte = 8'h00;
				endcase
			end
		end
	endfunction

	wire user_blk = ~dbg_mode_i & opt_wr_protect_i;
	wire page_prot = ~dbg_mode_i &
		prot_hit(open_page_reg, sector_protect_mask_reg);
	wire info_area_enable = flash_page_select_reg[`FPEC_INFO_AREA_ENABLE_BIT];
	wire ctrl_wr = reg_wr_i && reg_addr_i == `FPEC_ADDR_CTRL;
	wire page_wr = reg_wr_i && reg_addr_i == `FPEC_ADDR_PAGE;
	wire busy = state_reg == S_PROG || state_reg == S_PER ||
		state_reg == S_MER;
	// writes into the overlaid info window never reach the array
	wire info_tgt = info_area_enable && mem_addr_i[15:9] == `FPEC_INFO_BASE;
	wire in_page = dbg_mode_i ||
		mem_addr_i[15:9] == open_page_reg;
	wire prog_ok = state_reg == S_OPEN && mem_wr_i && !info_tgt &&
		in_page && !page_prot && !user_blk;

	// command and page-select sequencing
	always @* begin
		state_next = state_reg;
		if (busy) begin
			if (work_done_reg)
				state_next = (state_reg == S_PROG) ? S_OPEN : S_LOCK;
		end else if (ctrl_wr) begin
			case (reg_wdata_i)
			`FPEC_CMD_UNLK1: state_next = (state_reg == S_LOCK) ? S_U1 : S_LOCK;
			`FPEC_CMD_UNLK2: begin
				if (state_reg != S_U1)
					state_next = S_LOCK;
				else if (dbg_mode_i)
					state_next = S_OPEN;
				else
					state_next = S_U2;
			end
			`FPEC_CMD_PROT: state_next = S_PROT;
			`FPEC_CMD_PERASE: begin
				if (state_reg == S_OPEN && !page_prot && !user_blk)
					state_next = S_PER;
				else
					state_next = S_LOCK;
			end
			`FPEC_CMD_MERASE: begin
				if (state_reg == S_OPEN && dbg_mode_i)
					state_next = S_MER;
				else
					state_next = S_LOCK;
			end
			default: state_next = S_LOCK;
			endcase
		end else if (page_wr) begin
			case (state_reg)
			S_LOCK: state_next = S_LOCK;
			S_U2: state_next = (reg_wdata_i[6:0] == open_page_reg) ?
				S_OPEN : S_LOCK;
			S_PROT: state_next = S_PROT;
			S_OPEN: state_next = dbg_mode_i ? S_OPEN : S_LOCK;
			default: state_next = S_LOCK;
			endcase
		end else if (prog_ok) begin
			state_next = S_PROG;
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= S_LOCK;
			flash_page_select_reg <= 8'h00;
			sector_protect_mask_reg <= 8'h00;
			clock_khz_setting_reg <= 16'h0000;
			open_page_reg <= 7'h00;
			tmr_start_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tmr_start_reg <= 1'b0;
			if (reg_wr_i && reg_addr_i == `FPEC_ADDR_FRQH)
				clock_khz_setting_reg[15:8] <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == `FPEC_ADDR_FRQL)
				clock_khz_setting_reg[7:0] <= reg_wdata_i;
			if (page_wr && !busy) begin
				if (state_reg == S_PROT) begin
					if (dbg_mode_i)
						sector_protect_mask_reg <= reg_wdata_i;
					else
						sector_protect_mask_reg <= sector_protect_mask_reg |
							reg_wdata_i;
				end else begin
					flash_page_select_reg <= reg_wdata_i;
					if (state_reg == S_LOCK || dbg_mode_i)
						open_page_reg <= reg_wdata_i[6:0];
				end
			end
			if (!busy && state_next != state_reg &&
				(state_next == S_PROG || state_next == S_PER ||
				state_next == S_MER))
				tmr_start_reg <= 1'b1;
		end
	end

	fpec_timer u_timer (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(tmr_start_reg),
		.khz_i(clock_khz_setting_reg),
		.us_i(state_reg == S_PROG ? `FPEC_T_PROG_US : ERASE_US[15:0]),
		.done_o(tmr_done)
	);

	// array work: program latches byte, erase walks 512 bytes per page
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			pg_addr_reg <= 16'h0000;
			pg_data_reg <= 8'h00;
			er_idx_reg <= 9'h000;
			er_page_reg <= 7'h00;
			work_done_reg <= 1'b0;
		end else begin
			work_done_reg <= 1'b0;
			if (prog_ok && !busy && !ctrl_wr && !page_wr) begin
				pg_addr_reg <= mem_addr_i;
				pg_data_reg <= mem_wdata_i;
			end
			if (state_next == S_PER && !busy)
				er_page_reg <= open_page_reg;
			if (state_next == S_MER && !busy)
				er_page_reg <= 7'h00;
			if (state_reg == S_PROG && tmr_done) begin
				flash_mem[pg_addr_reg] <= flash_mem[pg_addr_reg] &
					pg_data_reg;
				work_done_reg <= 1'b1;
			end
			if ((state_reg == S_PER || state_reg == S_MER) && tmr_done)
				er_idx_reg <= 9'h001;
			if (er_idx_reg != 9'h000 || (tmr_done &&
				(state_reg == S_PER || state_reg == S_MER))) begin
				flash_mem[{er_page_reg, er_idx_reg - 9'h001}] <=
					`FPEC_ERASED;
				if (er_idx_reg == 9'h000) begin
					er_idx_reg <= 9'h001;
				end else if (er_idx_reg == 9'h1FF) begin
					flash_mem[{er_page_reg, 9'h1FF}] <= `FPEC_ERASED;
					// index must stay nonzero or the page walk stalls
					if (state_reg == S_MER && er_page_reg != PAGES) begin
						er_page_reg <= er_page_reg + 7'h01;
						er_idx_reg <= 9'h001;
					end else begin
						er_idx_reg <= 9'h000;
						work_done_reg <= 1'b1;
					end
				end else begin
					er_idx_reg <= er_idx_reg + 9'h001;
				end
			end
		end
	end

	// outputs and read data
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
			mem_rdata_o <= 8'h00;
			mem_rvalid_o <= 1'b0;
			cpu_stall_o <= 1'b0;
			flash_state_field_o <= `FPEC_ST_LOCK;
		end else begin
			cpu_stall_o <= busy || (state_next == S_PROG ||
				state_next == S_PER || state_next == S_MER);
			case (state_next)
			S_U1: flash_state_field_o <= `FPEC_ST_U1;
			S_U2: flash_state_field_o <= `FPEC_ST_U2;
			S_OPEN: flash_state_field_o <= `FPEC_ST_OPEN;
			S_PROT: flash_state_field_o <= `FPEC_ST_PROT;
			S_PROG: flash_state_field_o <= `FPEC_ST_PROG;
			S_PER: flash_state_field_o <= `FPEC_ST_PERASE;
			S_MER: flash_state_field_o <= `FPEC_ST_MERASE;
			default: flash_state_field_o <= `FPEC_ST_LOCK;
			endcase
			if (reg_rd_i) begin
				case (reg_addr_i)
				`FPEC_ADDR_CTRL: reg_rdata_o <= {2'b00, flash_state_field_o};
				`FPEC_ADDR_PAGE: reg_rdata_o <= (state_reg == S_PROT) ?
					sector_protect_mask_reg : flash_page_select_reg;
				`FPEC_ADDR_FRQH: reg_rdata_o <= clock_khz_setting_reg[15:8];
				`FPEC_ADDR_FRQL: reg_rdata_o <= clock_khz_setting_reg[7:0];
				default: reg_rdata_o <= 8'h00;
				endcase
			end
			mem_rvalid_o <= (mem_rd_i || mem_fetch_i) && !busy;
			if ((mem_rd_i || mem_fetch_i) && !busy) begin
				if (mem_rd_i && info_area_enable &&
					mem_addr_i[15:9] == `FPEC_INFO_BASE)
					mem_rdata_o <= info_byte(mem_addr_i[8:0]);
				else if (mem_rd_i && dbg_mode_i && opt_rd_protect_i)
					mem_rdata_o <= 8'h00;
				else
					mem_rdata_o <= flash_mem[mem_addr_i];
			end
		end
	end
endmodule

// ==== sim/fpec_chk.sv ====
// port assertions for the flash program/erase controller
`timescale 1ns/10ps
module fpec_chk (
	// clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// requests
	input wire reg_wr_i,
	input wire [11:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire mem_wr_i,
	input wire mem_rd_i,
	input wire dbg_mode_i,
	input wire opt_wr_protect_i,
	// answers
	input wire mem_rvalid_o,
	input wire cpu_stall_o,
	input wire [5:0] flash_state_field_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire [5:0] st = flash_state_field_o;
	wire busy = |st[5:3];
	// control and page writes are ignored while busy, so only idle ones count
	wire cw = reg_wr_i && reg_addr_i == 12'hFF8 && !busy;
	wire [7:0] d = reg_wdata_i;
	// shadow of protect mask and open page, kept from the rules
	reg [7:0] pm;
	reg [6:0] pg;
	wire pw = reg_wr_i && reg_addr_i == 12'hFF9 && !busy;
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			pm <= 8'h00;
			pg <= 7'h00;
		end else if (pw && st == 6'h04) begin
			pm <= dbg_mode_i ? d : (pm | d);
		end else if (pw && (st == 6'h00 || dbg_mode_i)) begin
			pg <= d[6:0];
		end
	end
	wire ok_pe = dbg_mode_i || (!opt_wr_protect_i && !pm[pg[6:4]]);
	property p_rst;
		$fell(sys_rst_i) |-> st == 6'h00 && !cpu_stall_o;
	endproperty
	a_rst: assert property (p_rst) else $error("not locked after reset");
	property p_stall;
		cpu_stall_o == (busy || $past(busy));
	endproperty
	a_stall: assert property (p_stall) else $error("stall mismatch");
	property p_u2;
		cw && !dbg_mode_i && st == 6'h01 && d == 8'h8C |=> st == 6'h02;
	endproperty
	a_u2: assert property (p_u2) else $error("second code lost");
	property p_lock;
		cw && d == 8'h00 |=> st == 6'h00;
	endproperty
	a_lock: assert property (p_lock) else $error("00h did not lock");
	property p_bad;
		cw && !(d inside {8'h00, 8'h73, 8'h8C, 8'h95, 8'h63, 8'h5E})
			|=> st == 6'h00;
	endproperty
	a_bad: assert property (p_bad) else $error("bad code kept open");
	property p_prot;
		cw && d == 8'h5E |=> st == 6'h04;
	endproperty
	a_prot: assert property (p_prot) else $error("5Eh not taken");
	property p_pe;
		cw && ok_pe && st == 6'h03 && d == 8'h95
			|=> st == 6'h10 ##1 cpu_stall_o;
	endproperty
	a_pe: assert property (p_pe) else $error("page erase missing");
	property p_me;
		cw && !dbg_mode_i && d == 8'h63 |=> st != 6'h20;
	endproperty
	a_me: assert property (p_me) else $error("user mass erase");
	property p_wp;
		mem_wr_i && st == 6'h03 && !dbg_mode_i && opt_wr_protect_i
			|=> st == 6'h03 [*2];
	endproperty
	a_wp: assert property (p_wp) else $error("protected write ran");
	property p_rd;
		mem_rd_i && !busy |=> mem_rvalid_o;
	endproperty
	a_rd: assert property (p_rd) else $error("read not served");
	c_prog: cover property (st == 6'h08);
	c_pe: cover property (st == 6'h10);
	c_prot: cover property (st == 6'h04);
	c_me: cover property (st == 6'h20);
endmodule
bind fpec_ctrl fpec_chk u_fpec_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i), .dbg_mode_i(dbg_mode_i),
	.opt_wr_protect_i(opt_wr_protect_i), .mem_rvalid_o(mem_rvalid_o),
	.cpu_stall_o(cpu_stall_o), .flash_state_field_o(flash_state_field_o));

// ==== sim/fpec_host.sv ====
// host model: register and program memory strokes
`timescale 1ns/10ps
module fpec_host (
	// clock
	input wire clk_i,
	// register port
	output reg reg_wr_o,
	output reg reg_rd_o,
	output reg [11:0] reg_addr_o,
	output reg [7:0] reg_wdata_o,
	input wire [7:0] reg_rdata_i,
	// memory port
	output reg mem_wr_o,
	output reg mem_rd_o,
	output reg mem_fetch_o,
	output reg [15:0] mem_addr_o,
	output reg [7:0] mem_wdata_o,
	input wire [7:0] mem_rdata_i,
	input wire [5:0] state_i
);
	initial begin
		{reg_wr_o, reg_rd_o, mem_wr_o, mem_rd_o, mem_fetch_o} = 5'h00;
		reg_addr_o = 12'h000;
		reg_wdata_o = 8'h00;
		mem_addr_o = 16'h0000;
		mem_wdata_o = 8'h00;
	end
	// released lines flip so stale values never look valid
	task rg(input logic rd, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = !rd;
		reg_rd_o = rd;
		@(negedge clk_i);
		{reg_wr_o, reg_rd_o} = 2'h0;
		q = reg_rdata_i;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask
	task mm(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_i);
		mem_addr_o = a;
		mem_wdata_o = d;
		{mem_fetch_o, mem_rd_o, mem_wr_o} = 3'h1 << k;
		@(negedge clk_i);
		{mem_fetch_o, mem_rd_o, mem_wr_o} = 3'h0;
		q = mem_rdata_i;
		mem_addr_o = ~a;
		mem_wdata_o = ~d;
	endtask
	task idle;
		for (int n = 0; n < 70000 && |state_i[5:3]; n++) @(negedge clk_i);
	endtask
	task unlock(input logic [7:0] p, input logic again);
		logic [7:0] q;
		rg(1'b0, 12'hFF8, 8'h00, q);
		rg(1'b0, 12'hFF9, p, q);
		rg(1'b0, 12'hFF8, 8'h73, q);
		rg(1'b0, 12'hFF8, 8'h8C, q);
		if (again)
			rg(1'b0, 12'hFF9, p, q);
	endtask
endmodule

// ==== sim/fpec_ctrl_test.sv ====
// self-checking bench for the flash program/erase controller
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module fpec_ctrl_test;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic dbg = 1'b0;
	logic owp = 1'b0;
	logic orp = 1'b0;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [7:0] q;
	wire rw, rr, mw, mr, mf, rv, stall;
	wire [11:0] ra;
	wire [7:0] rwd, rrd, mwd, mrd;
	wire [15:0] ma;
	wire [5:0] st;
	initial forever #12.5 clk_i = ~clk_i;
	fpec_ctrl #(.ERASE_US(5)) u_fpec_ctrl (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .reg_wr_i(rw), .reg_rd_i(rr),
		.reg_addr_i(ra), .reg_wdata_i(rwd), .reg_rdata_o(rrd),
		.mem_wr_i(mw), .mem_rd_i(mr), .mem_fetch_i(mf), .mem_addr_i(ma),
		.mem_wdata_i(mwd), .mem_rdata_o(mrd), .mem_rvalid_o(rv),
		.dbg_mode_i(dbg), .opt_wr_protect_i(owp), .opt_rd_protect_i(orp),
		.cpu_stall_o(stall), .flash_state_field_o(st));
	fpec_host u_fpec_host (.clk_i(clk_i), .reg_wr_o(rw), .reg_rd_o(rr),
		.reg_addr_o(ra), .reg_wdata_o(rwd), .reg_rdata_i(rrd),
		.mem_wr_o(mw), .mem_rd_o(mr), .mem_fetch_o(mf), .mem_addr_o(ma),
		.mem_wdata_o(mwd), .mem_rdata_i(mrd), .state_i(st));
	task w(input logic [11:0] a, input logic [7:0] d);
		u_fpec_host.rg(1'b0, a, d, q);
	endtask
	task r(input logic [11:0] a);
		u_fpec_host.rg(1'b1, a, 8'h00, q);
	endtask
	// memory stroke, then wait out any operation it started
	task m(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
		u_fpec_host.mm(k, a, d, q);
		u_fpec_host.idle;
	endtask
	task t_reset;
		sys_rst_i = 1'b1;
		repeat (5) @(negedge clk_i);
		sys_rst_i = 1'b0;
		r(12'hFF8);
		`CHK(q, 8'h00)
		w(12'hFF8, 8'h5E);
		r(12'hFF9);
		`CHK(q, 8'h00)
		w(12'hFF8, 8'h00);
		w(12'hFFA, 8'h03);
		w(12'hFFB, 8'hE8);
		$display("test reset done");
	endtask
	task t_erase;
		u_fpec_host.unlock(8'h02, 1'b1);
		r(12'hFF8);
		`CHK(q, 8'h03)
		w(12'hFF8, 8'h95);
		r(12'hFF8);
		`CHK(q, 8'h10)
		`CHK(stall, 1'b1)
		u_fpec_host.idle;
		r(12'hFF8);
		`CHK(q, 8'h00)
		m(2'd1, 16'h05FF, 8'h00);
		`CHK(q, 8'hFF)
		$display("test erase done");
	endtask
	task t_prog;
		u_fpec_host.unlock(8'h02, 1'b1);
		m(2'd0, 16'h0400, 8'hA5);
		m(2'd0, 16'h0400, 8'h5A);
		m(2'd1, 16'h0400, 8'h00);
		`CHK(q, 8'h00)
		m(2'd0, 16'h0600, 8'h00);
		r(12'hFF8);
		`CHK(q, 8'h03)
		owp = 1'b1;
		m(2'd0, 16'h0401, 8'h00);
		owp = 1'b0;
		w(12'hFF8, 8'h00);
		m(2'd0, 16'h0402, 8'h00);
		m(2'd1, 16'h0401, 8'h00);
		`CHK(q, 8'hFF)
		m(2'd1, 16'h0402, 8'h00);
		`CHK(q, 8'hFF)
		$display("test program done");
	endtask
	task t_seq;
		w(12'hFF8, 8'h00);
		w(12'hFF9, 8'h02);
		w(12'hFF8, 8'h8C);
		r(12'hFF8);
		`CHK(q, 8'h00)
		u_fpec_host.unlock(8'h02, 1'b0);
		w(12'hFF9, 8'h05);
		r(12'hFF8);
		`CHK(q, 8'h00)
		u_fpec_host.unlock(8'h02, 1'b1);
		w(12'hFF8, 8'h63);
		r(12'hFF8);
		`CHK(q, 8'h00)
		dbg = 1'b1;
		u_fpec_host.unlock(8'h02, 1'b0);
		r(12'hFF8);
		`CHK(q, 8'h03)
		w(12'hFF8, 8'h00);
		dbg = 1'b0;
		$display("test sequence done");
	endtask
	task t_info;
		u_fpec_host.unlock(8'h7F, 1'b1);
		w(12'hFF8, 8'h95);
		u_fpec_host.idle;
		u_fpec_host.unlock(8'hFF, 1'b1);
		m(2'd0, 16'hFE40, 8'h00);
		r(12'hFF8);
		`CHK(q, 8'h03)
		m(2'd1, 16'hFE40, 8'h00);
		`CHK(q, 8'h46)
		m(2'd1, 16'hFE53, 8'h00);
		`CHK(q, 8'h00)
		m(2'd2, 16'hFE40, 8'h00);
		`CHK(q, 8'hFF)
		w(12'hFF8, 8'h00);
		w(12'hFF9, 8'h00);
		$display("test info done");
	endtask
	task t_mass;
		dbg = 1'b1;
		u_fpec_host.unlock(8'h02, 1'b0);
		w(12'hFF8, 8'h63);
		r(12'hFF8);
		`CHK(q, 8'h20)
		u_fpec_host.idle;
		r(12'hFF8);
		`CHK(q, 8'h00)
		orp = 1'b1;
		m(2'd1, 16'h0400, 8'h00);
		`CHK(q, 8'h00)
		orp = 1'b0;
		m(2'd1, 16'h0400, 8'h00);
		`CHK(q, 8'hFF)
		m(2'd1, 16'h0600, 8'h00);
		`CHK(q, 8'hFF)
		dbg = 1'b0;
		$display("test mass erase done");
	endtask
	task t_prot;
		w(12'hFF8, 8'h00);
		w(12'hFF8, 8'h5E);
		r(12'hFF8);
		`CHK(q, 8'h04)
		w(12'hFF9, 8'h01);
		w(12'hFF9, 8'h00);
		r(12'hFF9);
		`CHK(q, 8'h01)
		w(12'hFF8, 8'h00);
		w(12'hFF9, 8'h02);
		r(12'hFF9);
		`CHK(q, 8'h02)
		u_fpec_host.unlock(8'h02, 1'b1);
		m(2'd0, 16'h0403, 8'h00);
		m(2'd1, 16'h0403, 8'h00);
		`CHK(q, 8'hFF)
		w(12'hFF8, 8'h95);
		r(12'hFF8);
		`CHK(q[5:4], 2'h0)
		$display("test protect done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			print_verdict;
		end
	end
	initial begin
		t_reset;
		t_erase;
		t_prog;
		t_seq;
		t_info;
		t_prot;
		t_mass;
		t_reset;
		print_verdict;
	end
endmodule
